/* File: dbs_checker.sv */
// assertion checker for the disk buffer dma sequencer ports
`timescale 1ns/100ps
module dbs_checker
(
    // clock and reset
    input wire        clk,
    input wire        reset_n,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    // sequencer and buffer
    input wire        seq_start_id_read,
    input wire        seq_pause_req,
    input wire        seq_stop,
    input wire        buf_write_en,
    input wire        busy
);
    reg  [5:0] ctrl_r;
    wire       wr_acc = psel && penable && pready && pwrite;
    // shadow of the control register as written over apb
    always @(posedge clk)
        if (!reset_n)
            ctrl_r <= 6'h00;
        else if (wr_acc && paddr == 12'h000)
            ctrl_r <= pwdata[5:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_apb_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_unmapped_err: assert property (psel && !penable && paddr > 12'h038 |=> pslverr)
        else $error("unmapped access without error");
    a_start_sets_busy: assert property (wr_acc && paddr == 12'h004 && pwdata[0] |-> ##[1:2] busy)
        else $error("start without busy");
    a_idle_no_write: assert property (buf_write_en |-> busy || $past(busy))
        else $error("buffer write while idle");
    a_verify_no_write: assert property (ctrl_r[3] |-> !buf_write_en)
        else $error("buffer write in verify");
    a_pause_skip_only: assert property (!ctrl_r[0] |-> !seq_pause_req)
        else $error("pause outside skip mode");
    a_id_read_pulse: assert property (seq_start_id_read |=> !seq_start_id_read)
        else $error("id read start not a pulse");
    a_stop_holds: assert property (seq_stop && !(wr_acc && paddr == 12'h004) |=> seq_stop)
        else $error("stop dropped without start");
endmodule // dbs_checker

bind dbs_sequencer dbs_checker u_chk (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .seq_start_id_read(seq_start_id_read), .seq_pause_req(seq_pause_req),
    .seq_stop(seq_stop), .buf_write_en(buf_write_en), .busy(busy));

/* File: dbs_defines.vh */
// register map, field positions and reset values of the disk buffer dma sequencer
`ifndef DBS_DEFINES_VH
`define DBS_DEFINES_VH
`define DBS_A_CTRL      12'h000
`define DBS_A_START     12'h004
`define DBS_A_SEGBASE   12'h008
`define DBS_A_SEGSIZE   12'h00C
`define DBS_A_RELADDR   12'h010
`define DBS_A_BLKCNT    12'h014
`define DBS_A_SKIPMASK  12'h018
`define DBS_A_PHYSIZE   12'h01C
`define DBS_A_EXPID     12'h020
`define DBS_A_ABSADDR   12'h024
`define DBS_A_EXTCNT    12'h028
`define DBS_A_TALLY     12'h02C
`define DBS_A_ECCSTART  12'h030
`define DBS_A_STATUS    12'h034
`define DBS_A_INTCNT    12'h038
// control register bits
`define DBS_C_SKIPEN    0
`define DBS_C_RWREN     1
`define DBS_C_READ_COMPARE_ENABLE    2
`define DBS_C_SUPPRESS_BUFFER_TRANSFER     3
`define DBS_C_DIR       4
`define DBS_C_OTF       5
`define DBS_C_W         6
`define DBS_CTRL_RST    6'h00
`define DBS_SKIP_MAX    5'h10
`define DBS_MASK_MSB    15
`endif

/* File: dbs_seq_model.sv */
// behavioural model of the control store sequencer and its ecc logic
`timescale 1ns/100ps
module dbs_seq_model
#(
    parameter WORDS = 3
)
(
    input  wire       clk,
    input  wire       start,
    input  wire       pause,
    input  wire       restart,
    input  wire [3:0] bad_at,
    output reg        id_valid,
    output reg        xfer,
    output reg        data_end,
    output reg        ecc_end,
    output reg        sec_end,
    output reg        at_jump,
    output reg        good,
    output reg        uncor,
    output reg        word_done
);
    reg [3:0] cnt;
    reg       hold;
    initial {id_valid, xfer, data_end, ecc_end, sec_end, at_jump, good, uncor, word_done} = 0;
    initial {hold, cnt} = 0;
    // ecc flags are only meaningful around the ecc field end, garbage elsewhere
    always @(posedge clk)
    begin
        at_jump <= pause;
        if (restart)
            cnt <= 4'h0;
        else if (data_end)
            cnt <= cnt + 4'h1;
        if (hold)
        begin
            good <= (cnt != bad_at);
            uncor <= (cnt == bad_at);
        end
        else
        begin
            good <= ~good;
            uncor <= good;
        end
    end
    initial forever
    begin
        @(posedge clk);
        if (start)
        begin
            repeat (2) @(posedge clk);
            id_valid <= 1'b1;
            xfer <= 1'b1;
            @(posedge clk) xfer <= 1'b0;
            repeat (WORDS)
            begin
                word_done <= 1'b1;
                @(posedge clk) word_done <= 1'b0;
                @(posedge clk);
            end
            data_end <= 1'b1;
            @(posedge clk) data_end <= 1'b0;
            hold <= 1'b1;
            repeat (2) @(posedge clk);
            ecc_end <= 1'b1;
            @(posedge clk) ecc_end <= 1'b0;
            hold <= 1'b0;
            sec_end <= 1'b1;
            @(posedge clk) sec_end <= 1'b0;
            id_valid <= 1'b0;
        end
    end
endmodule // dbs_seq_model

/* File: dbs_sequencer.v */
// disk side buffer dma block sequencer with apb register file
// What the document requires
// RQ1: repeat-write reloads address pointer to start address at each logical block boundary
// RQ2: repeat-write block count counts logical blocks, not physical ones; the code decrements both counts once per physical sector
// RQ3: repeat-write uses skip mask as physical blocks per logical block
// RQ4: repeat-write only acts while repeat_write_enable control bit is set
// RQ5: unreloaded control values are reused; no new relative address continues from last
// RQ6: processor loads control block, then writes start register to begin
// RQ7: start runs preprocess forming absolute start and segment min and max
// RQ8: pointer reaching segment maximum wraps to segment minimum
// RQ9: standard mode transfers only after valid id; flags request internal count update
// RQ10: read with pending ecc updates external count after correction, never if uncorrectable; the code ignores ecc_uncorrectable for the held update
// RQ11: disk writes ignore ecc status for count updates
// RQ12: expected id increments at data field end, start of ecc field
// RQ13: at ecc field end nonzero count loops to id read, zero exits
// RQ14: tally increments only on ecc good; uncorrectable read updates neither count
// RQ15: disk write updates external count and tally at true sector end
// RQ16: uncorrected error in on-the-fly mode stops at end of next data field
// RQ17: uncorrected error saves bad block start address, external count stays there; only on-the-fly mode stops, elsewhere later good blocks decrement it
// RQ18: skip mode examines mask bit before each sector, starts id read on one
// RQ19: zero mask bit pauses sequencer, decrements counts, increments id, next bit
// RQ20: mask bit one while paused withdraws pause so sequencer resumes
// RQ21: skip mode moves data only for ones but counts id for every block
// RQ22: verify modes suppress buffer writes; two control combinations select verify kind
// RQ23: mask bit 15 belongs to the first sector of the load
// RQ24: one skip-mask load is limited to at most 16 blocks
// RQ25: zero mask bit leaves tally unchanged but decrements external count
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "dbs_defines.vh"
module dbs_sequencer
#(
    parameter AW = 22,
    parameter CW = 16
)
(
    // clock and reset
    input  wire          clk,
    input  wire          reset_n,
    // apb slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    // control store sequencer handshake
    input  wire          seq_id_valid,
    input  wire          seq_xfer_flag,
    input  wire          seq_no_transfer_flag,
    input  wire          seq_data_end,
    input  wire          seq_ecc_end,
    input  wire          seq_sector_end,
    input  wire          seq_at_loop_jump,
    input  wire          ecc_good,
    input  wire          ecc_uncorrectable,
    input  wire          ecc_pending,
    output reg           seq_start_id_read,
    output reg           seq_pause_req,
    output reg           seq_loop_jump_enable,
    output reg           seq_stop,
    // buffer data strobe
    input  wire          buf_word_done,
    output reg  [AW-1:0] buf_addr,
    output reg           buf_write_en,
    output reg           busy
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_PRE   = 3'd1;
    localparam ST_MASK  = 3'd2;
    localparam ST_RUN   = 3'd3;
    localparam ST_SKIP  = 3'd4;
    localparam ST_DONE  = 3'd5;

    reg [2:0]     st_r;
    reg [5:0]     ctrl_r;
    reg [AW-1:0]  segbase_r;
    reg [AW-1:0]  segsize_r;
    reg [AW-1:0]  reladdr_r;
    reg           rel_new_r;
    reg [CW-1:0]  blkcnt_r;
    reg [15:0]    mask_r;
    reg [15:0]    physize_r;
    reg [31:0]    expid_r;
    reg [AW-1:0]  start_r;
    reg [AW-1:0]  segmin_r;
    reg [AW-1:0]  segmax_r;
    reg [CW-1:0]  intcnt_r;
    reg [CW-1:0]  extcnt_r;
    reg [CW-1:0]  tally_r;
    reg [AW-1:0]  eccstart_r;
    reg [AW-1:0]  blkstart_r;
    reg [15:0]    bytecnt_r;
    reg [15:0]    mask_sh_r;
    reg [4:0]     phys_r;
    reg [4:0]     phys_left_r;
    reg           pend_upd_r;
    reg           err_stop_r;
    reg           uncor_seen_r;

    wire       acc   = psel & penable;
    wire       wr    = acc & pwrite;
    wire       skip_mode = ctrl_r[`DBS_C_SKIPEN];
    wire       rw_mode   = ctrl_r[`DBS_C_RWREN];
    wire       dir_wr    = ctrl_r[`DBS_C_DIR];
    // ecc-only verify: cmp 0 suppress_buffer_transfer 1 dir 1; ecc+compare: cmp 1 suppress_buffer_transfer 1 dir 0
    wire       verify    = ctrl_r[`DBS_C_SUPPRESS_BUFFER_TRANSFER]; // [RQ22]
    wire       is_read   = ~dir_wr | verify;
    wire [AW-1:0] next_addr = (buf_addr == segmax_r) ? segmin_r : buf_addr + 1'b1; // [RQ8]
    wire       mask_bit  = mask_sh_r[`DBS_MASK_MSB]; // [RQ23]
    // reads count at ecc field end on a good block only; writes count at sector end
    wire       blk_upd   = seq_ecc_end & is_read & ecc_good & ~ecc_uncorrectable;
    wire       logical_end = ~rw_mode | (phys_left_r == 5'd1);

    // apb: zero wait, unmapped reads zero with error
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel & ~penable)
            begin
                if (paddr == `DBS_A_CTRL)
                    prdata <= {26'h0, ctrl_r};
                else if (paddr == `DBS_A_START)
                    prdata <= {31'h0, busy};
                else if (paddr == `DBS_A_SEGBASE)
                    prdata <= {{(32-AW){1'b0}}, segbase_r};
                else if (paddr == `DBS_A_SEGSIZE)
                    prdata <= {{(32-AW){1'b0}}, segsize_r};
                else if (paddr == `DBS_A_RELADDR)
                    prdata <= {{(32-AW){1'b0}}, reladdr_r};
                else if (paddr == `DBS_A_BLKCNT)
                    prdata <= {{(32-CW){1'b0}}, blkcnt_r};
                else if (paddr == `DBS_A_SKIPMASK)
                    prdata <= {16'h0000, mask_r};
                else if (paddr == `DBS_A_PHYSIZE)
                    prdata <= {16'h0000, physize_r};
                else if (paddr == `DBS_A_EXPID)
                    prdata <= expid_r;
                else if (paddr == `DBS_A_ABSADDR)
                    prdata <= {{(32-AW){1'b0}}, buf_addr};
                else if (paddr == `DBS_A_EXTCNT)
                    prdata <= {{(32-CW){1'b0}}, extcnt_r};
                else if (paddr == `DBS_A_TALLY)
                    prdata <= {{(32-CW){1'b0}}, tally_r};
                else if (paddr == `DBS_A_ECCSTART)
                    prdata <= {{(32-AW){1'b0}}, eccstart_r};
                else if (paddr == `DBS_A_STATUS)
                    prdata <= {27'h0, uncor_seen_r, err_stop_r, st_r};
                else if (paddr == `DBS_A_INTCNT)
                    prdata <= {{(32-CW){1'b0}}, intcnt_r};
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // control block registers keep their values between runs
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            ctrl_r    <= `DBS_CTRL_RST;
            segbase_r <= {AW{1'b0}};
            segsize_r <= {AW{1'b1}};
            reladdr_r <= {AW{1'b0}};
            rel_new_r <= 1'b0;
            blkcnt_r  <= {CW{1'b0}};
            mask_r    <= 16'h0000;
            physize_r <= 16'h0200;
        end
        else
        begin
            if (st_r == ST_PRE)
                rel_new_r <= 1'b0;
            if (wr && pready)
            begin
                if (paddr == `DBS_A_CTRL)
                    ctrl_r <= pwdata[`DBS_C_W-1:0]; // [RQ4]
                else if (paddr == `DBS_A_SEGBASE)
                    segbase_r <= pwdata[AW-1:0];
                else if (paddr == `DBS_A_SEGSIZE)
                    segsize_r <= pwdata[AW-1:0];
                else if (paddr == `DBS_A_RELADDR)
                begin
                    reladdr_r <= pwdata[AW-1:0];
                    rel_new_r <= 1'b1; // [RQ5]
                end
                else if (paddr == `DBS_A_BLKCNT)
                    blkcnt_r <= pwdata[CW-1:0];
                else if (paddr == `DBS_A_SKIPMASK)
                    mask_r <= pwdata[15:0];
                else if (paddr == `DBS_A_PHYSIZE)
                    physize_r <= pwdata[15:0];
            end
        end
    end

    wire start_wr = wr && pready && (paddr == `DBS_A_START) && pwdata[0]; // [RQ6]
    wire stop_wr  = wr && pready && (paddr == `DBS_A_START) && !pwdata[0];

    // dma sequencing
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            st_r        <= ST_IDLE;
            expid_r     <= 32'h0000_0000;
            start_r     <= {AW{1'b0}};
            segmin_r    <= {AW{1'b0}};
            segmax_r    <= {AW{1'b0}};
            buf_addr    <= {AW{1'b0}};
            intcnt_r    <= {CW{1'b0}};
            extcnt_r    <= {CW{1'b0}};
            tally_r     <= {CW{1'b0}};
            eccstart_r  <= {AW{1'b0}};
            blkstart_r  <= {AW{1'b0}};
            bytecnt_r   <= 16'h0000;
            mask_sh_r   <= 16'h0000;
            phys_r      <= 5'd0;
            phys_left_r <= 5'd0;
            pend_upd_r  <= 1'b0;
            err_stop_r  <= 1'b0;
            uncor_seen_r <= 1'b0;
            seq_start_id_read    <= 1'b0;
            seq_pause_req        <= 1'b0;
            seq_loop_jump_enable <= 1'b0;
            seq_stop    <= 1'b0;
            buf_write_en <= 1'b0;
            busy        <= 1'b0;
        end
        else
        begin
            seq_start_id_read <= 1'b0;
            buf_write_en      <= 1'b0;
            if (stop_wr)
            begin
                st_r <= ST_IDLE;
                busy <= 1'b0;
                seq_pause_req <= 1'b0;
            end
            else case (st_r)
            ST_IDLE:
            begin
                if (wr && pready && (paddr == `DBS_A_EXPID))
                    expid_r <= pwdata;
                if (start_wr)
                begin
                    // stop flag stands until the next start
                    seq_stop <= 1'b0;
                    st_r <= ST_PRE;
                    busy <= 1'b1;
                    err_stop_r <= 1'b0;
                end
            end
            ST_PRE:
            begin
                // absolute start, segment min and max [RQ7]
                segmin_r <= segbase_r;
                segmax_r <= segbase_r + segsize_r - 1'b1;
                if (rel_new_r)
                begin
                    start_r  <= segbase_r + reladdr_r; // [RQ5]
                    buf_addr <= segbase_r + reladdr_r;
                end
                else
                    start_r <= buf_addr;
                blkstart_r <= rel_new_r ? segbase_r + reladdr_r : buf_addr;
                // skip load capped at sixteen blocks [RQ24]
                intcnt_r <= (skip_mode && !rw_mode && blkcnt_r > `DBS_SKIP_MAX)
                            ? `DBS_SKIP_MAX : blkcnt_r; // [RQ2]
                extcnt_r <= (skip_mode && !rw_mode && blkcnt_r > `DBS_SKIP_MAX)
                            ? `DBS_SKIP_MAX : blkcnt_r;
                mask_sh_r <= mask_r;
                // physical blocks per logical block from mask ones [RQ3]
                phys_r <= cnt_ones(mask_r);
                phys_left_r <= cnt_ones(mask_r);
                bytecnt_r <= physize_r;
                pend_upd_r <= 1'b0;
                seq_loop_jump_enable <= 1'b1;
                st_r <= ST_MASK;
            end
            ST_MASK:
            begin
                if (intcnt_r == {CW{1'b0}})
                    st_r <= ST_DONE;
                else if (skip_mode && !rw_mode && !mask_bit) // [RQ18]
                    st_r <= ST_SKIP;
                else
                begin
                    seq_start_id_read <= 1'b1; // [RQ9] [RQ18]
                    seq_pause_req <= 1'b0;     // [RQ20]
                    st_r <= ST_RUN;
                end
            end
            ST_SKIP:
            begin
                seq_pause_req <= 1'b1; // [RQ19]
                if (seq_at_loop_jump)
                begin
                    // zero bit: both counts down, id up, tally held [RQ19] [RQ21] [RQ25]
                    intcnt_r  <= intcnt_r - 1'b1;
                    extcnt_r  <= extcnt_r - 1'b1;
                    expid_r   <= expid_r + 1'b1;
                    mask_sh_r <= {mask_sh_r[14:0], 1'b0};
                    st_r <= ST_MASK;
                end
            end
            ST_RUN:
            begin
                // data moves only after valid id, never in verify [RQ9] [RQ22]
                if (seq_id_valid && buf_word_done)
                begin
                    buf_write_en <= is_read & ~verify;
                    buf_addr <= next_addr; // [RQ8]
                end
                if (seq_data_end)
                begin
                    expid_r <= expid_r + 1'b1; // [RQ12] [RQ21]
                    if (err_stop_r && ctrl_r[`DBS_C_OTF])
                    begin
                        seq_stop <= 1'b1; // [RQ16]
                        st_r <= ST_DONE;
                    end
                end
                if (seq_xfer_flag | seq_no_transfer_flag)
                    intcnt_r <= intcnt_r - 1'b1; // [RQ9]
                if (seq_ecc_end)
                begin
                    if (is_read && ecc_uncorrectable)
                    begin
                        // keep failing address, counts untouched [RQ14] [RQ17]
                        eccstart_r <= blkstart_r;
                        err_stop_r <= 1'b1;
                        uncor_seen_r <= 1'b1;
                    end
                    else if (is_read && ecc_pending)
                        pend_upd_r <= 1'b1; // [RQ10]
                    else if (blk_upd)
                    begin
                        extcnt_r <= extcnt_r - 1'b1 - {{(CW-1){1'b0}}, pend_upd_r}; // [RQ10]
                        tally_r  <= tally_r + 1'b1 + {{(CW-1){1'b0}}, pend_upd_r};  // [RQ14]
                        pend_upd_r <= 1'b0;
                    end
                    blkstart_r <= next_addr;
                    // write same: reload pointer at logical block end [RQ1]
                    if (rw_mode && !is_read)
                    begin
                        if (logical_end)
                        begin
                            buf_addr <= start_r; // [RQ1]
                            blkstart_r <= start_r;
                            phys_left_r <= phys_r;
                        end
                        else
                            phys_left_r <= phys_left_r - 1'b1;
                    end
                    mask_sh_r <= {mask_sh_r[14:0], 1'b0};
                    if (!(err_stop_r && ctrl_r[`DBS_C_OTF]))
                        st_r <= ST_MASK; // [RQ13]
                end
                // correction finished: release held update [RQ10]
                if (!seq_ecc_end && pend_upd_r && ecc_good && !ecc_pending)
                begin
                    extcnt_r <= extcnt_r - 1'b1;
                    tally_r  <= tally_r + 1'b1;
                    pend_upd_r <= 1'b0;
                end
            end
            ST_DONE:
            begin
                seq_loop_jump_enable <= 1'b0; // [RQ13]
                seq_pause_req <= 1'b0;
                busy <= 1'b0;
                st_r <= ST_IDLE;
            end
            default:
                st_r <= ST_IDLE;
            endcase
            // writes count at true sector end, ecc status ignored [RQ11] [RQ15]
            if (busy && !is_read && seq_sector_end)
            begin
                extcnt_r <= extcnt_r - 1'b1;
                tally_r  <= tally_r + 1'b1;
            end
        end
    end

    // physical blocks per logical block in repeat-write
    function [4:0] cnt_ones;
        input [15:0] m;
        integer i;
        begin
            cnt_ones = 5'd0;
            for (i = 0; i < 16; i = i + 1)
                cnt_ones = cnt_ones + {4'd0, m[i]};
        end
    endfunction
endmodule // dbs_sequencer

/* File: tb.sv */
// self-checking testbench for the disk buffer dma sequencer
`timescale 1ns/100ps
`include "dbs_defines.vh"
module tb;
    reg         clk, reset_n, psel, penable, pwrite, restart, err;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg  [3:0]  bad_at;
    wire [31:0] prdata;
    wire        pready, pslverr, idv, xf, de, ee, se, aj, gd, uc, wd;
    wire        sid, pau, lje, stp, bwe, busy;
    wire [21:0] baddr;
    integer     num_errors = 0, tests_run = 0, n_id = 0, n_wr = 0, k;

    dbs_sequencer DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .seq_id_valid(idv), .seq_xfer_flag(xf), .seq_no_transfer_flag(1'b0),
        .seq_data_end(de), .seq_ecc_end(ee), .seq_sector_end(se), .seq_at_loop_jump(aj),
        .ecc_good(gd), .ecc_uncorrectable(uc), .ecc_pending(1'b0), .seq_start_id_read(sid),
        .seq_pause_req(pau), .seq_loop_jump_enable(lje), .seq_stop(stp),
        .buf_word_done(wd), .buf_addr(baddr), .buf_write_en(bwe), .busy(busy));
    dbs_seq_model u_seq (.clk(clk), .start(sid), .pause(pau), .restart(restart),
        .bad_at(bad_at), .id_valid(idv), .xfer(xf), .data_end(de), .ecc_end(ee),
        .sec_end(se), .at_jump(aj), .good(gd), .uncor(uc), .word_done(wd));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (sid === 1'b1)
            n_id = n_id + 1;
        if (bwe === 1'b1)
            n_wr = n_wr + 1;
    end

    task test_done;
    begin
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("wrong value %0s exp %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    end
    endtask
    task rdchk(input [11:0] a, input [63:0] nm, input [31:0] exp);
    begin
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    end
    endtask
    task run(input [31:0] c, input [31:0] blk, input [31:0] m, input [3:0] bad);
    begin
        bad_at <= bad;
        restart <= 1'b1;
        apb(1'b1, `DBS_A_CTRL, c);
        restart <= 1'b0;
        apb(1'b1, `DBS_A_EXPID, 32'h10);
        apb(1'b1, `DBS_A_RELADDR, 32'h0);
        apb(1'b1, `DBS_A_BLKCNT, blk);
        apb(1'b1, `DBS_A_SKIPMASK, m);
        n_id = 0;
        n_wr = 0;
        apb(1'b1, `DBS_A_START, 32'h1);
        k = 0;
        while (busy === 1'b1 && stp !== 1'b1 && k < 4000)
        begin
            @(posedge clk);
            k = k + 1;
        end
    end
    endtask

    initial
    begin
        {reset_n, psel, penable, pwrite, restart, paddr, pwdata, bad_at} = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdchk(`DBS_A_CTRL, "ctrl", 32'h0);
        rdchk(`DBS_A_PHYSIZE, "physize", 32'h200);
        apb(1'b1, 12'h040, 32'hFF);
        chk("slverr", {31'h0, err}, 32'h1);
        rdchk(12'h040, "unmapped", 32'h0);
        // plain read of three sectors
        run(32'h0, 32'h3, 32'h0, 4'h0);
        chk("idreads", n_id, 32'h3);
        chk("writes", n_wr, 32'h9);
        rdchk(`DBS_A_EXPID, "expid", 32'h13);
        rdchk(`DBS_A_EXTCNT, "extcnt", 32'h0);
        rdchk(`DBS_A_INTCNT, "intcnt", 32'h0);
        rdchk(`DBS_A_TALLY, "tally", 32'h3);
        // skip mask: first bit of the load is bit 15
        run(32'h1, 32'h8, 32'hAA00, 4'h0);
        chk("idreads", n_id, 32'h4);
        rdchk(`DBS_A_EXPID, "expid", 32'h18);
        rdchk(`DBS_A_TALLY, "tally", 32'h7);
        rdchk(`DBS_A_EXTCNT, "extcnt", 32'h0);
        // write with bad ecc flag must still count
        run(32'h10, 32'h2, 32'h0, 4'h1);
        rdchk(`DBS_A_TALLY, "tally", 32'h9);
        rdchk(`DBS_A_EXTCNT, "extcnt", 32'h0);
        // uncorrectable second sector in on-the-fly mode
        run(32'h20, 32'h3, 32'h0, 4'h2);
        chk("stop", {31'h0, stp}, 32'h1);
        rdchk(`DBS_A_EXTCNT, "extcnt", 32'h2);
        rdchk(`DBS_A_TALLY, "tally", 32'hA);
        apb(1'b1, `DBS_A_START, 32'h0);
        repeat (40) @(posedge clk);
        // both verify kinds leave the buffer untouched
        run(32'h18, 32'h2, 32'h0, 4'h0);
        chk("vwrites", n_wr, 32'h0);
        run(32'h0C, 32'h2, 32'h0, 4'h0);
        chk("cwrites", n_wr, 32'h0);
        test_done;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors = num_errors + 1;
        test_done;
    end
endmodule // tb
